//--- ubf_consts.svh
// Constants for the upstream burst FEC framer.
// Assumes a 10 MHz ref_clk and a 32-bit word-aligned Avalon-MM register map.
//
// Operation
// RULE1 - With shortened mode, burst data is coded in full codewords of k bytes until it runs out.
// RULE2 - A leftover below k bytes goes into a shortened last codeword, padded with zeros.
// RULE3 - A shortened codeword never holds fewer than 16 information bytes.
// RULE4 - With shortened mode, zeros are appended up to the end of the grant.
// RULE5 - The leftover is padded up to a size between 16 and k that is at least the leftover.
// RULE6 - After the data, zero codewords of k bytes follow while one fits, then a short one.
// RULE7 - No short zero codeword is made when under 16 bytes of grant remain.
// RULE8 - Bytes are blocked, coded, scrambled, put behind the preamble, mapped, then sent.
// RULE9 - Each packet is cut into blocks of one codeword's data capacity.
// RULE10 - Each block is Reed-Solomon coded, and coding can be switched off.
// RULE11 - Bursts start at the scheduled time, in QPSK or 16QAM.
// RULE12 - Five symbol rates from 160 to 2560 ksym/s, each twice the one before.
// RULE13 - In fixed mode the last codeword is zero-filled to k, then zero codewords fill the grant.
// RULE14 - With coding on, no codeword holds fewer than 16 information bytes.
// RULE15 - Codeword setup, mode, coding enable and grant are latched at burst start.
`ifndef UBF_CONSTS_SVH
`define UBF_CONSTS_SVH
// ----------------------------------------
// Register map
// ----------------------------------------
`define UBF_REG_CTRL 5'h00
`define UBF_REG_CODE 5'h04
`define UBF_REG_GRANT 5'h08
`define UBF_REG_LAUNCH 5'h0C
`define UBF_REG_PRE 5'h10
`define UBF_REG_STATUS 5'h14
`define UBF_REG_TIME 5'h18
`define UBF_CTRL_START 0
`define UBF_CTRL_FEC 1
`define UBF_CTRL_SHORT 2
`define UBF_CTRL_QAM 3
`define UBF_CTRL_RATE 6:4
`define UBF_ST_ERR 1
`define UBF_ST_OVR 2
// ----------------------------------------
// Coding and timing
// ----------------------------------------
`define UBF_MIN_INFO 16'd16
`define UBF_MAX_PAR 5'd20
`define UBF_MAX_RATE 3'd4
`define UBF_GF_POLY 8'h1D
`define UBF_SCR_SEED 15'h4A95
`define UBF_CLK_HZ 64'd10000000
`define UBF_BASE_RATE_HZ 64'd160000
`define UBF_NCO_INC 24'((`UBF_BASE_RATE_HZ * (64'd1 << 24)) / `UBF_CLK_HZ)
`endif

//--- ubf_pkg.sv
// Types shared by the upstream burst FEC framer.
// Assumes ubf_consts.svh supplies all numeric constants.
package ubf_pkg;
	// ----------------------------------------
	// Per-burst configuration
	// ----------------------------------------
	typedef struct packed {
		logic fec;
		logic shrt;
		logic qam16;
		logic [2:0] rate;
		logic [7:0] k;
		logic [4:0] par;
		logic [15:0] cap;
		logic [7:0] pre_byte;
		logic [7:0] pre_len;
		logic [31:0] launch;
	} ubf_cfg_s;
	typedef struct packed {
		logic [1:0] i;
		logic [1:0] q;
	} ubf_sym_s;
	typedef enum logic [3:0] {
		S_IDLE, S_GEN, S_WAIT, S_PRE, S_DATA, S_PAR, S_NEXT, S_DRAIN, S_END
	} ubf_state_e;
endpackage

//--- ubf_framer.sv
// Upstream burst framer: block, RS code, scramble, preamble, map and time bursts.
// Assumes a packet byte stream in and a modulator that takes one symbol per sym_valid.
`include "ubf_consts.svh"
module ubf_framer (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic in_valid,
	input wire logic [7:0] in_data,
	input wire logic in_last,
	output logic in_ready,
	output logic sym_valid,
	output ubf_pkg::ubf_sym_s sym,
	output logic burst_active
);
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [7:0] gf_mul(input logic [7:0] a, input logic [7:0] b);
		logic [7:0] r;
		logic [7:0] x;
		r = 8'h00;
		x = a;
		for (int i = 0; i < 8; i++) begin
			if (b[i]) r = r ^ x;
			x = {x[6:0], 1'b0} ^ (x[7] ? `UBF_GF_POLY : 8'h00);
		end
		return r;
	endfunction
	function automatic logic [22:0] scr(input logic [14:0] s, input logic [7:0] d);
		logic [14:0] l;
		logic [7:0] o;
		logic fb;
		l = s;
		o = 8'h00;
		for (int i = 7; i >= 0; i--) begin
			fb = l[14] ^ l[13];
			o[i] = d[i] ^ fb;
			l = {l[13:0], fb};
		end
		return {l, o};
	endfunction
	// ----------------------------------------
	// Register bus
	// ----------------------------------------
	logic [6:0] r_ctrl, next_r_ctrl;
	logic [12:0] r_code, next_r_code;
	logic [23:0] r_grant, next_r_grant;
	logic [31:0] r_launch, next_r_launch;
	logic [15:0] r_pre, next_r_pre;
	logic [31:0] tstamp, next_rdata;
	logic next_wait, start, next_start, acc;
	logic [1:0] clr;
	ubf_pkg::ubf_state_e st, next_st;
	logic err, ovr, next_err, next_ovr;
	always_comb begin
		acc = (avs_read | avs_write) & avs_waitrequest;
		next_wait = ~acc;
		next_start = 1'b0;
		clr = 2'b00;
		next_r_ctrl = r_ctrl;
		next_r_code = r_code;
		next_r_grant = r_grant;
		next_r_launch = r_launch;
		next_r_pre = r_pre;
		next_rdata = avs_readdata;
		if (acc && avs_read) begin
			unique case (avs_address)
				`UBF_REG_CTRL: next_rdata = {25'h0, r_ctrl[6:1], 1'b0};
				`UBF_REG_CODE: next_rdata = {19'h0, r_code};
				`UBF_REG_GRANT: next_rdata = {8'h00, r_grant};
				`UBF_REG_LAUNCH: next_rdata = r_launch;
				`UBF_REG_PRE: next_rdata = {16'h0, r_pre};
				`UBF_REG_STATUS: next_rdata = {29'h0, ovr, err, st != ubf_pkg::S_IDLE};
				`UBF_REG_TIME: next_rdata = tstamp;
				default: next_rdata = 32'h0;
			endcase
		end
		if (!avs_waitrequest && avs_write) begin
			unique case (avs_address)
				`UBF_REG_CTRL: begin
					next_r_ctrl = {avs_writedata[6:1], 1'b0};
					next_start = avs_writedata[`UBF_CTRL_START];
				end
				`UBF_REG_CODE: next_r_code = avs_writedata[12:0];
				`UBF_REG_GRANT: next_r_grant = avs_writedata[23:0];
				`UBF_REG_LAUNCH: next_r_launch = avs_writedata;
				`UBF_REG_PRE: next_r_pre = avs_writedata[15:0];
				`UBF_REG_STATUS: clr = avs_writedata[`UBF_ST_OVR:`UBF_ST_ERR];
				default: ;
			endcase
		end
	end
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h0;
			start <= 1'b0;
			r_ctrl <= 7'h0;
			r_code <= 13'h0;
			r_grant <= 24'h0;
			r_launch <= 32'h0;
			r_pre <= 16'h0;
			tstamp <= 32'h0;
		end else begin
			avs_waitrequest <= next_wait;
			avs_readdata <= next_rdata;
			start <= next_start;
			r_ctrl <= next_r_ctrl;
			r_code <= next_r_code;
			r_grant <= next_r_grant;
			r_launch <= next_r_launch;
			r_pre <= next_r_pre;
			tstamp <= tstamp + 32'h1;
		end
	end
	// ----------------------------------------
	// Input buffer
	// ----------------------------------------
	// Two entries keep full honest without a combinational ready path
	logic [8:0] fq [0:1];
	logic wp, rp, pop, push, next_wp, next_rp, next_in_ready;
	logic [1:0] fcnt, next_fcnt;
	logic fvalid;
	always_comb begin
		fvalid = fcnt != 2'd0;
		push = in_valid & in_ready;
		next_wp = wp ^ push;
		next_rp = rp ^ pop;
		next_fcnt = 2'(fcnt + {1'b0, push} - {1'b0, pop});
		next_in_ready = next_fcnt != 2'd2;
	end
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			wp <= 1'b0;
			rp <= 1'b0;
			fcnt <= 2'd0;
			in_ready <= 1'b0;
		end else begin
			wp <= next_wp;
			rp <= next_rp;
			fcnt <= next_fcnt;
			in_ready <= next_in_ready;
			if (push) fq[wp] <= {in_last, in_data};
		end
	end
	// ----------------------------------------
	// Framer
	// ----------------------------------------
	ubf_pkg::ubf_cfg_s cfg, next_cfg, lat;
	logic [7:0] g [0:20];
	logic [7:0] next_g [0:20];
	logic [7:0] gn [0:20];
	logic [7:0] p [0:19];
	logic [7:0] next_p [0:19];
	logic [7:0] pe [0:19];
	logic [7:0] ps [0:19];
	logic [7:0] alpha, next_alpha, cnt, next_cnt, cw, next_cw, tgt, next_tgt;
	logic [7:0] hold, next_hold, byt, fb;
	logic [15:0] cap, next_cap, kpp, avail;
	logic [14:0] lfsr, next_lfsr;
	logic hold_full, next_hold_full, done, next_done, next_active, take, bad, go;
	logic [3:0] bits;
	logic [22:0] sb;
	logic [15:0] min_info;
	assign fb = byt ^ p[5'(cfg.par - 5'd1)];
	genvar j;
	generate
		for (j = 0; j <= 20; j++) begin : g_gen
			if (j == 0) begin : g0
				assign gn[j] = gf_mul(alpha, g[j]);
			end else begin : gj
				assign gn[j] = g[j-1] ^ gf_mul(alpha, g[j]);
			end
		end
		for (j = 0; j < 20; j++) begin : g_enc
			if (j == 0) begin : e0
				assign pe[j] = gf_mul(fb, g[j]);
				assign ps[j] = 8'h00;
			end else begin : ej
				assign pe[j] = p[j-1] ^ gf_mul(fb, g[j]);
				assign ps[j] = p[j-1];
			end
		end
	endgenerate
	always_comb begin
		lat.fec = r_ctrl[`UBF_CTRL_FEC];
		lat.shrt = r_ctrl[`UBF_CTRL_SHORT];
		lat.qam16 = r_ctrl[`UBF_CTRL_QAM];
		lat.rate = r_ctrl[`UBF_CTRL_RATE];
		lat.k = r_code[7:0];
		lat.par = r_ctrl[`UBF_CTRL_FEC] ? r_code[12:8] : 5'd0;
		lat.cap = 16'(r_grant[7:0] * r_grant[15:8]);
		lat.cap = (lat.cap > {8'h00, r_grant[23:16]}) ? 16'(lat.cap - r_grant[23:16]) : 16'h0;
		lat.pre_byte = r_pre[7:0];
		lat.pre_len = r_pre[15:8];
		lat.launch = r_launch;
		// Odd parity counts cannot form an RS code
		bad = (lat.fec && ({8'h00, lat.k} < `UBF_MIN_INFO || lat.par > `UBF_MAX_PAR
			|| lat.par[0])) || lat.rate > `UBF_MAX_RATE || lat.k == 8'h00; // RULE14 RULE12
		min_info = cfg.fec ? `UBF_MIN_INFO : 16'd1;
		byt = done ? 8'h00 : fq[rp][7:0];
		sb = scr(lfsr, byt);
		go = !hold_full && (done || fvalid);
		avail = 16'(cap + {8'h00, cw} - {11'h0, cfg.par});
		kpp = (avail < {8'h00, cfg.k}) ? avail : {8'h00, cfg.k}; // RULE4
		if (kpp < 16'(cw + 8'd1)) kpp = 16'(cw + 8'd1);
		if (kpp < min_info) kpp = min_info; // RULE3 RULE5
		next_st = st;
		next_cfg = cfg;
		next_g = g;
		next_p = p;
		next_alpha = alpha;
		next_cnt = cnt;
		next_cw = cw;
		next_tgt = tgt;
		next_cap = cap;
		next_done = done;
		next_hold = hold;
		next_hold_full = hold_full & ~take;
		next_lfsr = lfsr;
		next_active = burst_active;
		next_err = err & ~clr[0];
		next_ovr = ovr & ~clr[1];
		pop = 1'b0;
		unique case (st)
			ubf_pkg::S_IDLE: if (start) begin
				next_cfg = lat; // RULE15
				next_alpha = 8'h01;
				next_cnt = 8'h00;
				for (int i = 0; i <= 20; i++) next_g[i] = (i == 0) ? 8'h01 : 8'h00;
				if (bad) next_err = 1'b1;
				else next_st = (lat.par != 5'd0) ? ubf_pkg::S_GEN : ubf_pkg::S_WAIT;
			end
			ubf_pkg::S_GEN: begin
				next_g = gn;
				next_alpha = gf_mul(alpha, 8'h02);
				next_cnt = cnt + 8'h01;
				if (cnt == {3'h0, 5'(cfg.par - 5'd1)}) next_st = ubf_pkg::S_WAIT;
			end
			ubf_pkg::S_WAIT: if (tstamp == cfg.launch) begin
				next_active = 1'b1; // RULE11
				next_cnt = 8'h00;
				next_lfsr = `UBF_SCR_SEED;
				next_cw = 8'h00;
				next_tgt = cfg.k; // RULE9
				next_done = 1'b0;
				next_cap = cfg.cap;
				for (int i = 0; i < 20; i++) next_p[i] = 8'h00;
				next_st = (cfg.pre_len == 8'h00) ? ubf_pkg::S_DATA : ubf_pkg::S_PRE;
			end
			ubf_pkg::S_PRE: if (!hold_full) begin
				next_hold = cfg.pre_byte; // RULE8
				next_hold_full = 1'b1;
				next_cnt = cnt + 8'h01;
				if (next_cnt == cfg.pre_len) next_st = ubf_pkg::S_DATA;
			end
			ubf_pkg::S_DATA: if (go) begin
				if (cap == 16'h0) begin
					next_ovr = 1'b1;
					next_st = done ? ubf_pkg::S_END : ubf_pkg::S_DRAIN;
				end else begin
					pop = !done;
					if (!done && fq[rp][8]) next_done = 1'b1;
					if (!done && fq[rp][8] && (cfg.shrt || !cfg.fec)) next_tgt = kpp[7:0]; // RULE2
					if (cfg.par != 5'd0) next_p = pe; // RULE10
					next_hold = sb[7:0];
					next_lfsr = sb[22:8];
					next_hold_full = 1'b1;
					next_cw = cw + 8'h01;
					next_cap = cap - 16'h1;
					next_cnt = 8'h00;
					if (next_cw >= next_tgt) next_st = (cfg.par != 5'd0) ? ubf_pkg::S_PAR : ubf_pkg::S_NEXT;
				end
			end
			ubf_pkg::S_PAR: if (!hold_full) begin
				sb = scr(lfsr, p[5'(cfg.par - 5'd1)]);
				next_hold = sb[7:0];
				next_lfsr = sb[22:8];
				next_hold_full = 1'b1;
				next_p = ps;
				next_cnt = cnt + 8'h01;
				if (cap != 16'h0) next_cap = cap - 16'h1;
				if (next_cnt == {3'h0, cfg.par}) next_st = ubf_pkg::S_NEXT;
			end
			ubf_pkg::S_NEXT: begin
				next_cw = 8'h00;
				next_tgt = cfg.k;
				for (int i = 0; i < 20; i++) next_p[i] = 8'h00;
				if (!done) next_st = ubf_pkg::S_DATA; // RULE1
				else if (cap >= 16'({8'h00, cfg.k} + cfg.par)) next_st = ubf_pkg::S_DATA; // RULE6 RULE13
				else if ((cfg.shrt || !cfg.fec) && cap >= 16'(min_info + cfg.par)) begin
					next_tgt = 8'(cap - cfg.par); // RULE6
					next_st = ubf_pkg::S_DATA;
				end else next_st = ubf_pkg::S_END; // RULE7
			end
			ubf_pkg::S_DRAIN: if (fvalid) begin
				pop = 1'b1;
				if (fq[rp][8]) next_st = ubf_pkg::S_END;
			end
			ubf_pkg::S_END: if (!hold_full && bits == 4'd0) begin
				next_active = 1'b0;
				next_st = ubf_pkg::S_IDLE;
			end
		endcase
	end
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			st <= ubf_pkg::S_IDLE;
			cfg <= '0;
			alpha <= 8'h01;
			cnt <= 8'h00;
			cw <= 8'h00;
			tgt <= 8'h00;
			cap <= 16'h0;
			done <= 1'b0;
			hold <= 8'h00;
			hold_full <= 1'b0;
			lfsr <= `UBF_SCR_SEED;
			burst_active <= 1'b0;
			err <= 1'b0;
			ovr <= 1'b0;
			for (int i = 0; i <= 20; i++) g[i] <= 8'h00;
			for (int i = 0; i < 20; i++) p[i] <= 8'h00;
		end else begin
			st <= next_st;
			cfg <= next_cfg;
			alpha <= next_alpha;
			cnt <= next_cnt;
			cw <= next_cw;
			tgt <= next_tgt;
			cap <= next_cap;
			done <= next_done;
			hold <= next_hold;
			hold_full <= next_hold_full;
			lfsr <= next_lfsr;
			burst_active <= next_active;
			err <= next_err | (st == ubf_pkg::S_IDLE && start && bad);
			ovr <= next_ovr;
			g <= next_g;
			p <= next_p;
		end
	end
	// ----------------------------------------
	// Symbol timing and mapping
	// ----------------------------------------
	// NCO timing: symbols jitter by one ref_clk, about a quarter of a symbol period at 2560 ksym/s
	logic [24:0] acc_sum;
	logic [23:0] nco, next_nco;
	logic [7:0] sh, next_sh, cur;
	logic [3:0] next_bits;
	logic next_sym_valid;
	ubf_pkg::ubf_sym_s next_sym;
	always_comb begin
		acc_sum = {1'b0, nco} + {1'b0, `UBF_NCO_INC << cfg.rate}; // RULE12
		next_nco = (st == ubf_pkg::S_WAIT) ? 24'h0 : acc_sum[23:0];
		take = acc_sum[24] && burst_active && bits == 4'd0 && hold_full;
		cur = take ? hold : sh;
		next_sh = sh;
		next_bits = bits;
		next_sym = sym;
		next_sym_valid = 1'b0;
		if (acc_sum[24] && burst_active && (take || bits != 4'd0)) begin
			next_sym_valid = 1'b1;
			if (cfg.qam16) begin
				next_sym.i = {cur[7], cur[7] ^ cur[5]};
				next_sym.q = {cur[6], cur[6] ^ cur[4]};
				next_sh = {cur[3:0], 4'h0};
				next_bits = 4'((take ? 4'd8 : bits) - 4'd4);
			end else begin
				next_sym.i = {2{cur[7]}};
				next_sym.q = {2{cur[6]}};
				next_sh = {cur[5:0], 2'b00};
				next_bits = 4'((take ? 4'd8 : bits) - 4'd2);
			end
		end
	end
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			nco <= 24'h0;
			sh <= 8'h00;
			bits <= 4'd0;
			sym <= '0;
			sym_valid <= 1'b0;
		end else begin
			nco <= next_nco;
			sh <= next_sh;
			bits <= next_bits;
			sym <= next_sym;
			sym_valid <= next_sym_valid;
		end
	end
	// ----------------------------------------
	// Checks
	// ----------------------------------------
	AST_MIN16: assert property (@(posedge ref_clk) disable iff (rst) // RULE14 RULE3
		(st == ubf_pkg::S_PAR) |-> ({8'h00, tgt} >= `UBF_MIN_INFO))
		else $error("codeword below minimum size");
	AST_SHORT_MAX: assert property (@(posedge ref_clk) disable iff (rst) // RULE5
		(st == ubf_pkg::S_PAR) |-> (tgt <= cfg.k && cw == tgt))
		else $error("codeword size outside range");
	AST_FULL: assert property (@(posedge ref_clk) disable iff (rst) // RULE1
		(st == ubf_pkg::S_DATA && !done) |-> (tgt == cfg.k))
		else $error("data codeword not full length");
	AST_PARITY: assert property (@(posedge ref_clk) disable iff (rst) // RULE10
		(st == ubf_pkg::S_DATA && go && cap != 16'h0 && next_cw >= next_tgt && cfg.par != 5'd0)
		|=> (st == ubf_pkg::S_PAR) ##1 (st == ubf_pkg::S_PAR))
		else $error("parity phase not entered");
	AST_UNCODED: assert property (@(posedge ref_clk) disable iff (rst) // RULE10
		(!cfg.fec) |-> (st != ubf_pkg::S_PAR && st != ubf_pkg::S_GEN))
		else $error("parity sent with coding off");
	AST_ZERO_CW: assert property (@(posedge ref_clk) disable iff (rst) // RULE6 RULE13
		(st == ubf_pkg::S_NEXT && done && cap >= 16'({8'h00, cfg.k} + cfg.par))
		|=> (st == ubf_pkg::S_DATA && tgt == cfg.k && cw == 8'h00))
		else $error("zero codeword missing");
	AST_NO_SHORT: assert property (@(posedge ref_clk) disable iff (rst) // RULE7
		(st == ubf_pkg::S_NEXT && done && cfg.fec && cap < 16'(`UBF_MIN_INFO + cfg.par))
		|=> (st == ubf_pkg::S_END))
		else $error("short zero codeword too small");
	AST_LAUNCH: assert property (@(posedge ref_clk) disable iff (rst) // RULE11
		(st == ubf_pkg::S_WAIT && tstamp == cfg.launch) |=> (burst_active && !$past(burst_active)))
		else $error("burst not launched on time");
	AST_ORDER: assert property (@(posedge ref_clk) disable iff (rst) // RULE8
		(st == ubf_pkg::S_PRE || st == ubf_pkg::S_WAIT || st == ubf_pkg::S_GEN) |-> !pop)
		else $error("data taken before preamble");
endmodule

//--- ubf_demod_model.sv
// Headend demodulator model: turns framer symbols back into bytes and timing figures.
// Assumes one shared ref_clk and the framer's QPSK and 16QAM level coding.
module ubf_demod_model (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic qam16,
	input wire logic sym_valid,
	input wire ubf_pkg::ubf_sym_s sym,
	input wire logic burst_active,
	output int byte_cnt,
	output logic [15:0] head,
	output int gap_min,
	output int gap_max,
	output int rise_cyc,
	output int cyc
);
	logic [7:0] acc;
	logic was_active;
	int nbits;
	int last_cyc;
	// ----------------------------------------
	// Demapping
	// ----------------------------------------
	// Counters restart at each burst so one stale symbol cannot leak into the next count
	always @(posedge ref_clk) begin
		cyc = rst ? 0 : cyc + 1;
		if (burst_active === 1'b1 && was_active !== 1'b1) begin
			rise_cyc = cyc;
			byte_cnt = 0;
			nbits = 0;
			gap_min = 1 << 30;
			gap_max = 0;
			last_cyc = -1;
		end
		was_active = burst_active;
		if (sym_valid === 1'b1) begin
			if (last_cyc >= 0) begin
				gap_min = (cyc - last_cyc < gap_min) ? cyc - last_cyc : gap_min;
				gap_max = (cyc - last_cyc > gap_max) ? cyc - last_cyc : gap_max;
			end
			last_cyc = cyc;
			if (qam16) begin
				acc = {acc[3:0], sym.i[1], sym.q[1], sym.i[1] ^ sym.i[0], sym.q[1] ^ sym.q[0]};
				nbits += 4;
			end else begin
				acc = {acc[5:0], sym.i[1], sym.q[1]};
				nbits += 2;
			end
			if (nbits == 8) begin
				if (byte_cnt < 2) begin
					head = {head[7:0], acc};
				end
				byte_cnt++;
				nbits = 0;
			end
		end
	end
endmodule

//--- ubf_framer_test.sv
// Self-checking bench for the upstream burst framer.
// Assumes the demodulator model and the framer share ref_clk.
`include "ubf_consts.svh"
module ubf_framer_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk, rst, avs_read, avs_write, avs_waitrequest;
	logic in_valid, in_last, in_ready, sym_valid, burst_active, qam16;
	logic [4:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, rd;
	logic [7:0] in_data;
	logic [15:0] head;
	ubf_pkg::ubf_sym_s sym;
	int byte_cnt, gap_min, gap_max, rise_cyc, cyc, fail_count, check_count;

	ubf_framer DUT (.ref_clk(ref_clk), .rst(rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.in_valid(in_valid), .in_data(in_data), .in_last(in_last), .in_ready(in_ready),
		.sym_valid(sym_valid), .sym(sym), .burst_active(burst_active));
	ubf_demod_model far_end (.ref_clk(ref_clk), .rst(rst), .qam16(qam16),
		.sym_valid(sym_valid), .sym(sym), .burst_active(burst_active),
		.byte_cnt(byte_cnt), .head(head), .gap_min(gap_min), .gap_max(gap_max),
		.rise_cyc(rise_cyc), .cyc(cyc));

	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %0t %s got %0h exp %0h", $time, msg, got, exp);
		end
	endtask
	task automatic check_in(input int got, input int lo, input int hi, input string msg);
		check_count++;
		if (got < lo || got > hi) begin
			fail_count++;
			$display("[FAIL] %0t %s got %0d exp %0d..%0d", $time, msg, got, lo, hi);
		end
	endtask
	// Request stands until waitrequest is seen low at a rising edge; read data is taken there
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= ~wr;
		do begin
			@(posedge ref_clk);
		end while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge ref_clk);
	endtask
	// A byte stands until in_ready is seen high at the edge that takes it
	task automatic send_pkt(input int n);
		for (int i = 0; i < n; i++) begin
			in_valid <= 1'b1;
			in_data <= 8'(i + 8'h21);
			in_last <= (i == n - 1);
			do begin
				@(posedge ref_clk);
			end while (in_ready !== 1'b1);
		end
		in_valid <= 1'b0;
		in_last <= 1'b0;
	endtask
	task automatic burst(input logic [31:0] ctrl, input logic [31:0] code,
		input logic [31:0] grant, input int n);
		int t;
		qam16 <= ctrl[3];
		bus(1'b1, `UBF_REG_CODE, code);
		bus(1'b1, `UBF_REG_GRANT, grant);
		bus(1'b1, `UBF_REG_PRE, 32'h000002C3);
		bus(1'b0, `UBF_REG_TIME, 32'h0);
		t = int'(rd);
		bus(1'b1, `UBF_REG_LAUNCH, rd + 32'h12C);
		bus(1'b1, `UBF_REG_CTRL, ctrl | 32'h1);
		bus(1'b1, `UBF_REG_GRANT, 32'h0);
		fork
			send_pkt(n);
			begin
				for (int c = 0; c < 40000 && burst_active !== 1'b1; c++) @(posedge ref_clk);
				for (int c = 0; c < 40000 && burst_active !== 1'b0; c++) @(posedge ref_clk);
			end
		join
		repeat (2) @(posedge ref_clk);
		// Burst rises one edge after TIME meets LAUNCH; the model sees it one edge later
		check_in(rise_cyc - t, 302, 302, "launch time");
		check(32'(head), 32'h0000C3C3, "preamble");
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_regs;
		bus(1'b1, `UBF_REG_CODE, 32'h00000420);
		bus(1'b0, `UBF_REG_CODE, 32'h0);
		check(rd, 32'h00000420, "code readback");
		bus(1'b0, 5'h1C, 32'h0);
		check(rd, 32'h0, "unmapped read");
		bus(1'b0, `UBF_REG_STATUS, 32'h0);
		check(rd, 32'h0, "idle status");
	endtask
	// Fifteen info bytes with coding on must be refused
	task automatic t_cfg_err;
		bus(1'b1, `UBF_REG_CODE, 32'h0000040F);
		bus(1'b1, `UBF_REG_CTRL, 32'h00000043);
		bus(1'b0, `UBF_REG_STATUS, 32'h0);
		check(rd, 32'h2, "cfg error");
		check(32'(burst_active), 32'h0, "no burst");
		bus(1'b1, `UBF_REG_STATUS, 32'h2);
		bus(1'b0, `UBF_REG_STATUS, 32'h0);
		check(rd, 32'h0, "cfg error clear");
	endtask
	// Grants sized so the last shortened codeword keeps 16 bytes or more
	task automatic t_short;
		burst(32'h46, 32'h0420, 32'h00000A0A, 40);
		check(32'(byte_cnt), 32'h66, "short fill to grant");
		burst(32'h46, 32'h0420, 32'h00000A06, 40);
		check(32'(byte_cnt), 32'h3E, "short last codeword");
	endtask
	task automatic t_nofill;
		burst(32'h46, 32'h0420, 32'h000E0A0A, 40);
		check(32'(byte_cnt), 32'h4A, "no short zero codeword");
	endtask
	task automatic t_fixed;
		burst(32'h4A, 32'h0420, 32'h00000A0B, 40);
		check(32'(byte_cnt), 32'h6E, "fixed fill");
	endtask
	// Coding off at every rate; spacing is one NCO period, floor or floor plus one
	task automatic t_rates;
		int lo;
		for (int r = 0; r < 5; r++) begin
			lo = 16777216 / (268435 << r);
			burst(32'(r << 4), 32'h0420, 32'h00000802, 10);
			check(32'(byte_cnt), 32'h12, "uncoded fill");
			check_in(gap_min, lo, lo + 1, "symbol gap min");
			check_in(gap_max, lo, lo + 1, "symbol gap max");
		end
	endtask
	// Packet longer than the grant: output stops at the grant end, the rest is drained
	task automatic t_overrun;
		burst(32'h40, 32'h0420, 32'h00000802, 20);
		check(32'(byte_cnt), 32'h12, "overrun cut at grant");
		bus(1'b0, `UBF_REG_STATUS, 32'h0);
		check(rd, 32'h4, "overrun flag");
		bus(1'b1, `UBF_REG_STATUS, 32'h4);
		bus(1'b0, `UBF_REG_STATUS, 32'h0);
		check(rd, 32'h0, "overrun clear");
	endtask
	task automatic close_out;
		if (fail_count == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// ----------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------
	initial begin
		rst = 1'b1;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 5'h00;
		avs_writedata = 32'h0;
		in_valid = 1'b0;
		in_last = 1'b0;
		in_data = 8'h00;
		qam16 = 1'b0;
		fail_count = 0;
		check_count = 0;
		repeat (5) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		t_regs;
		t_cfg_err;
		t_short;
		t_nofill;
		t_fixed;
		t_rates;
		t_overrun;
		close_out;
	end
	// Whole run needs about 20000 cycles; three times that means a hang
	initial begin
		repeat (60000) @(posedge ref_clk);
		fail_count++;
		close_out;
	end
endmodule
